// [logic/dgpio_pkg.sv]
package dgpio_pkg;

	// ----------------------------------------------------------------
	// Register map (file-register addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_BANK_A_LATCH = 8'h05;
	localparam logic [7:0] ADDR_BANK_B_LATCH = 8'h06;
	localparam logic [7:0] ADDR_OPTIONS      = 8'h81;
	localparam logic [7:0] ADDR_BANK_A_DIR   = 8'h85;
	localparam logic [7:0] ADDR_BANK_B_DIR   = 8'h86;
	localparam logic [7:0] ADDR_ANALOG_CFG   = 8'h9F;

	// ----------------------------------------------------------------
	// Widths, field positions, reset values
	// ----------------------------------------------------------------
	localparam int         BANK_A_WIDTH     = 5;
	localparam int         BANK_B_WIDTH     = 8;
	localparam int         PULLUP_N_BIT     = 7;
	localparam int         TIMER_PIN_BIT    = 4;
	localparam int         WATCH_LO_BIT     = 4;
	localparam logic [4:0] BANK_A_DIR_RESET = 5'h1F;
	localparam logic [3:0] BANK_A_LAT_RESET = 4'h0;
	localparam logic [7:0] BANK_B_DIR_RESET = 8'hFF;
	localparam logic [7:0] OPTIONS_RESET    = 8'hFF;
	localparam logic [1:0] ANALOG_CFG_RESET = 2'h0;
	localparam logic [7:0] BANK_B_LAT_POR   = 8'h00;

	// ----------------------------------------------------------------
	// Carrier for one file-register access
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dgpio_access_t;

endpackage

// [logic/dgpio_analog_map.sv]
`timescale 1ns/100ps
// Decodes the two analog configuration bits into a per-pin analog mask for bank A bits 3:0.
module dgpio_analog_map (
	input  wire logic [1:0] cfg,
	output logic      [3:0] analog_mask
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// 0: all four analog, 1: all four analog, 2: bits 1:0 analog,
	// 3: all digital.
	always_comb begin
		case (cfg)
			2'h0:    analog_mask = 4'hF;
			2'h1:    analog_mask = 4'hF;
			2'h2:    analog_mask = 4'h3;
			default: analog_mask = 4'h0;
		endcase
	end

endmodule

// [logic/dgpio_sync.sv]
`timescale 1ns/100ps
// Two-flop synchroniser for a bundle of pin levels.
module dgpio_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stage1 <= '0;
			dout   <= '0;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end

endmodule

// [logic/dgpio_port.sv]
`timescale 1ns/100ps
// Behaviour
// - Bank A output latch is five bits, one per pin.
// - Direction one floats the driver; zero drives the latch onto the pin.
// - Data register read returns pin levels; write updates only the latch.
// - Writes store read-modified pin levels into the output latch.
// - Bank A bit 4 is open drain and feeds timer external clock.
// - Shared peripheral pins need not support general-purpose use.
// - Two analog configuration bits choose digital or analog per low bank A pin.
// - After power-on, analog-capable pins are analog and read zero.
// - Unimplemented register bits read as zero.
// - Reset values of latches, direction and analog configuration.
// - Bank B is eight bidirectional bits with matching direction register.
// - Clearing option bit 7 enables all bank B weak pull-ups.
// - Output-configured bank B pins have pull-up off.
// - Power-on disables pull-ups; option register resets to all ones.
// - Only input-configured bank B upper four pins join change detection.
// - Inputs compared with last-read value; mismatches ORed set change flag.
// - Pending change can wake the device from sleep.
// - Any bank B data access refreshes the reference, ending mismatch.
// - Persisting mismatch keeps setting flag; software ends mismatch then clears.
// - Change coinciding with a read may fail to set the flag.
module dgpio_port #(
	parameter int A_WIDTH = dgpio_pkg::BANK_A_WIDTH,
	parameter int B_WIDTH = dgpio_pkg::BANK_B_WIDTH
) (
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire logic                  por,
	input  wire dgpio_pkg::dgpio_access_t bus,
	output logic      [7:0]            rdata,
	input  wire logic                  flag_clear,
	output logic                       pin_change_flag,
	output logic                       wake,
	input  wire logic [A_WIDTH-1:0]    bank_a_in,
	output logic      [A_WIDTH-1:0]    bank_a_out,
	output logic      [A_WIDTH-1:0]    bank_a_oe,
	output logic                       timer_ext_clock_in,
	output logic      [3:0]            analog_select,
	input  wire logic [B_WIDTH-1:0]    bank_b_in,
	output logic      [B_WIDTH-1:0]    bank_b_out,
	output logic      [B_WIDTH-1:0]    bank_b_oe,
	output logic      [B_WIDTH-1:0]    bank_b_pullup
);

	// ----------------------------------------------------------------
	// Registers and synchronised pins
	// ----------------------------------------------------------------
	logic [A_WIDTH-1:0] pin_bank_a_latch;
	logic [A_WIDTH-1:0] pin_bank_a_direction;
	logic [B_WIDTH-1:0] pin_bank_b_latch;
	logic [B_WIDTH-1:0] pin_bank_b_direction;
	logic [7:0]         timer_and_pullup_options;
	logic [1:0]         analog_pin_config;
	logic [A_WIDTH-1:0] a_sync;
	logic [B_WIDTH-1:0] b_sync;
	logic [3:0]         analog_mask;
	logic [3:0]         watch_ref;
	logic [A_WIDTH-1:0] a_read;
	logic [3:0]         mismatch;
	logic               wr_a;
	logic               wr_b;
	logic               rd_b;
	logic [7:0]         next_rdata;
	logic [3:0]         a_latch_lo;
	logic               a_latch_hi;
	logic               wr_a_dir;
	logic               wr_b_dir;
	logic               wr_opt;
	logic               wr_cfg;
	logic               b_access;
	logic [2:0]         settle;
	logic               live_change;

	dgpio_sync #(.WIDTH(A_WIDTH)) u_sync_a (
		.mclk  (mclk),
		.reset (reset),
		.din   (bank_a_in),
		.dout  (a_sync)
	);

	dgpio_sync #(.WIDTH(B_WIDTH)) u_sync_b (
		.mclk  (mclk),
		.reset (reset),
		.din   (bank_b_in),
		.dout  (b_sync)
	);

	dgpio_analog_map u_analog (
		.cfg         (analog_pin_config),
		.analog_mask (analog_mask)
	);

	// ----------------------------------------------------------------
	// Access decode
	// ----------------------------------------------------------------
	// Full eight-bit address compare; no register is mirrored here.
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ref_addr);
		hit = (addr == ref_addr);
	endfunction

	assign wr_a = bus.wr && hit(bus.addr, dgpio_pkg::ADDR_BANK_A_LATCH);
	assign wr_b = bus.wr && hit(bus.addr, dgpio_pkg::ADDR_BANK_B_LATCH);
	assign rd_b = bus.rd && hit(bus.addr, dgpio_pkg::ADDR_BANK_B_LATCH);
	// One strobe per register keeps each write block a single compare
	assign wr_a_dir = bus.wr && hit(bus.addr, dgpio_pkg::ADDR_BANK_A_DIR);
	assign wr_b_dir = bus.wr && hit(bus.addr, dgpio_pkg::ADDR_BANK_B_DIR);
	assign wr_opt   = bus.wr && hit(bus.addr, dgpio_pkg::ADDR_OPTIONS);
	assign wr_cfg   = bus.wr && hit(bus.addr, dgpio_pkg::ADDR_ANALOG_CFG);
	assign b_access = rd_b || wr_b;
	assign pin_bank_a_latch = {a_latch_hi, a_latch_lo};

	// Analog pins read as zero through the data register
	assign a_read = a_sync & ~{1'b0, analog_mask};

	// ----------------------------------------------------------------
	// Bank A latch, direction and analog configuration
	// ----------------------------------------------------------------
	// The CPU performs the read-modify-write: it fetches pin levels, changes
	// them and the result arrives here as wdata; the latch takes it whole.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			a_latch_lo <= dgpio_pkg::BANK_A_LAT_RESET;
		end else if (wr_a) begin
			a_latch_lo <= bus.wdata[3:0];
		end
	end

	// Bit 4 is unknown at power-on and unchanged otherwise; zero stands in for unknown.
	always_ff @(posedge mclk) begin
		if (por) begin
			a_latch_hi <= 1'b0;
		end else if (wr_a) begin
			a_latch_hi <= bus.wdata[A_WIDTH-1];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pin_bank_a_direction <= dgpio_pkg::BANK_A_DIR_RESET;
		end else if (wr_a_dir) begin
			pin_bank_a_direction <= bus.wdata[A_WIDTH-1:0];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			analog_pin_config <= dgpio_pkg::ANALOG_CFG_RESET;
		end else if (wr_cfg) begin
			analog_pin_config <= bus.wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Bank B latch, direction, options
	// ----------------------------------------------------------------
	// Latch survives non-power-on resets, so it is cleared only by por.
	always_ff @(posedge mclk) begin
		if (por) begin
			pin_bank_b_latch <= dgpio_pkg::BANK_B_LAT_POR;
		end else if (wr_b) begin
			pin_bank_b_latch <= bus.wdata[B_WIDTH-1:0];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pin_bank_b_direction <= dgpio_pkg::BANK_B_DIR_RESET;
		end else if (wr_b_dir) begin
			pin_bank_b_direction <= bus.wdata[B_WIDTH-1:0];
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			timer_and_pullup_options <= dgpio_pkg::OPTIONS_RESET;
		end else if (wr_opt) begin
			timer_and_pullup_options <= bus.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Change detection on the upper four bank B pins
	// ----------------------------------------------------------------
	assign mismatch = (b_sync[7:4] ^ watch_ref)
		& pin_bank_b_direction[7:4];

	// ----------------------------------------------------------------
	// Reference settle after reset
	// ----------------------------------------------------------------
	// The synchroniser shows zeros until it has filled; the reference
	// tracks the pins meanwhile so leaving reset cannot raise a false change.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			settle <= 3'h0;
		end else begin
			settle <= {settle[1:0], 1'b1};
		end
	end

	assign live_change = |mismatch && settle[2];

	// Reference follows the pins on any data access. The !b_access gate on the
	// flag set makes a change in the access cycle itself miss the flag.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			watch_ref <= 4'h0;
		end else if (b_access || !settle[2]) begin
			watch_ref <= b_sync[7:4];
		end
	end

	// Set wins over a simultaneous clear.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			pin_change_flag <= 1'b0;
		end else if (live_change && !b_access) begin
			pin_change_flag <= 1'b1;
		end else if (flag_clear) begin
			pin_change_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			wake <= 1'b0;
		end else begin
			wake <= pin_change_flag || live_change;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bank_a_out <= '0;
		end else begin
			bank_a_out <= pin_bank_a_latch;
			// Open drain: drive only a low, never a high
			bank_a_out[dgpio_pkg::TIMER_PIN_BIT] <= 1'b0;
		end
	end

	// Bit 4 lets go whenever its latch is high, so an outside pull-up sets the level
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bank_a_oe <= '0;
		end else begin
			bank_a_oe <= ~pin_bank_a_direction;
			bank_a_oe[dgpio_pkg::TIMER_PIN_BIT] <=
				~pin_bank_a_direction[dgpio_pkg::TIMER_PIN_BIT]
				& ~pin_bank_a_latch[dgpio_pkg::TIMER_PIN_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Timer clock input and analog selection
	// ----------------------------------------------------------------
	// Timer input reads the pin whatever the direction; the timer itself
	// sits elsewhere, so general-purpose use of the pin is left to software.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			timer_ext_clock_in <= 1'b0;
		end else begin
			timer_ext_clock_in <= a_sync[dgpio_pkg::TIMER_PIN_BIT];
		end
	end

	// Direction keeps controlling analog pins; software keeps it set.
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			analog_select <= 4'h0;
		end else begin
			analog_select <= analog_mask;
		end
	end

	// ----------------------------------------------------------------
	// Bank B pin drivers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bank_b_out <= '0;
		end else begin
			bank_b_out <= pin_bank_b_latch;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bank_b_oe <= '0;
		end else begin
			bank_b_oe <= ~pin_bank_b_direction;
		end
	end

	// Pull-up only on input pins, so an output never fights its own pull-up
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			bank_b_pullup <= '0;
		end else begin
			bank_b_pullup <= {B_WIDTH{~timer_and_pullup_options[dgpio_pkg::PULLUP_N_BIT]}}
				& pin_bank_b_direction;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		next_rdata = 8'h00;
		if (hit(bus.addr, dgpio_pkg::ADDR_BANK_A_LATCH)) begin
			next_rdata[A_WIDTH-1:0] = a_read;
		end else if (hit(bus.addr, dgpio_pkg::ADDR_BANK_B_LATCH)) begin
			next_rdata = b_sync;
		end else if (hit(bus.addr, dgpio_pkg::ADDR_OPTIONS)) begin
			next_rdata = timer_and_pullup_options;
		end else if (hit(bus.addr, dgpio_pkg::ADDR_BANK_A_DIR)) begin
			next_rdata[A_WIDTH-1:0] = pin_bank_a_direction;
		end else if (hit(bus.addr, dgpio_pkg::ADDR_BANK_B_DIR)) begin
			next_rdata = pin_bank_b_direction;
		end else if (hit(bus.addr, dgpio_pkg::ADDR_ANALOG_CFG)) begin
			next_rdata[1:0] = analog_pin_config;
		end
	end

	// Captured on the access edge; pin levels seen here lag the pins by two edges
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			rdata <= next_rdata;
		end
	end

endmodule

// [test/dgpio_port_chk.sv]
`timescale 1ns/100ps
module dgpio_port_chk (
	input wire logic                    mclk,
	input wire logic                    reset,
	input wire dgpio_pkg::dgpio_access_t bus,
	input wire logic [7:0]              rdata,
	input wire logic                    flag_clear,
	input wire logic                    pin_change_flag,
	input wire logic                    wake,
	input wire logic [4:0]              bank_a_out,
	input wire logic [4:0]              bank_a_oe,
	input wire logic [3:0]              analog_select,
	input wire logic [7:0]              bank_b_oe,
	input wire logic [7:0]              bank_b_out,
	input wire logic [7:0]              bank_b_pullup
);
	// ------------------------------------------------------------
	// Port timing checks
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	logic wb;
	logic mapped;
	assign wb = bus.wr && bus.addr == dgpio_pkg::ADDR_BANK_B_LATCH;
	assign mapped = bus.addr inside {8'h05, 8'h06, 8'h81, 8'h85, 8'h86, 8'h9F};

	unmapped_reads_zero_a: assert property (bus.rd && !mapped |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	bank_a_upper_a: assert property (bus.rd && bus.addr == 8'h05 |=> rdata[7:5] == 3'h0)
		else $error("bank A upper bits not zero");
	latch_drive_a: assert property (wb ##1 !wb |=> bank_b_out == $past(bus.wdata, 2))
		else $error("bank B latch not driven");
	open_drain_a: assert property (bank_a_out[4] == 1'b0)
		else $error("open drain pin drives high");
	od_release_a: assert property (bus.wr && bus.addr == 8'h05 && bus.wdata[4] ##1 !bus.wr
		|=> !bank_a_oe[4])
		else $error("open drain pin not released");
	pullup_output_a: assert property ((bank_b_pullup & bank_b_oe) == 8'h00)
		else $error("pull-up on output pin");
	pullup_off_a: assert property (bus.wr && bus.addr == 8'h81 && bus.wdata[7] ##1 !bus.wr
		|=> bank_b_pullup == 8'h00)
		else $error("pull-ups on while disabled");
	flag_sticky_a: assert property (pin_change_flag && !flag_clear |=> pin_change_flag)
		else $error("change flag dropped");
	flag_wakes_a: assert property ($rose(pin_change_flag) |-> ##[0:1] wake)
		else $error("no wake on change flag");
	analog_off_a: assert property (bus.wr && bus.addr == 8'h9F && bus.wdata[1:0] == 2'h3
		##1 !bus.wr |=> analog_select == 4'h0)
		else $error("analog select not cleared");
	cover property (pin_change_flag && flag_clear);
	cover property (wb);
	cover property ($rose(wake));
endmodule

bind dgpio_port dgpio_port_chk chk (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
	.flag_clear(flag_clear), .pin_change_flag(pin_change_flag), .wake(wake),
	.bank_a_out(bank_a_out), .bank_a_oe(bank_a_oe), .analog_select(analog_select),
	.bank_b_oe(bank_b_oe), .bank_b_out(bank_b_out), .bank_b_pullup(bank_b_pullup));

// [test/dgpio_pins.sv]
`timescale 1ns/100ps
module dgpio_pins (
	input  wire logic       mclk,
	input  wire logic [4:0] a_out,
	input  wire logic [4:0] a_oe,
	input  wire logic [4:0] a_ext,
	input  wire logic [4:0] a_en,
	output logic      [4:0] a_in,
	input  wire logic [7:0] b_out,
	input  wire logic [7:0] b_oe,
	input  wire logic [7:0] b_pu,
	input  wire logic [7:0] b_ext,
	input  wire logic [7:0] b_en,
	output logic      [7:0] b_in
);
	// ------------------------------------------------------------
	// Pin resolution
	// ------------------------------------------------------------
	// Undriven pins without a pull-up toggle so a stale level never reads as valid
	logic flt = 1'b0;
	always @(posedge mclk) flt <= ~flt;
	always_comb begin
		for (int i = 0; i < 5; i++) a_in[i] = a_oe[i] ? a_out[i] : a_en[i] ? a_ext[i] : flt;
		for (int i = 0; i < 8; i++) begin
			b_in[i] = b_oe[i] ? b_out[i] : b_en[i] ? b_ext[i] : b_pu[i] ? 1'b1 : flt;
		end
	end
endmodule

// [test/test_dual_gpio_port_with_change_irq.sv]
`timescale 1ns/100ps
module test_dual_gpio_port_with_change_irq;
	logic                     mclk = 1'b0;
	logic                     reset = 1'b1;
	logic                     por = 1'b1;
	dgpio_pkg::dgpio_access_t bus = '0;
	logic                     flag_clear = 1'b0;
	logic [7:0]               rdata;
	logic                     flag;
	logic                     wake;
	logic                     tclk;
	logic [3:0]               asel;
	logic [4:0]               a_in, a_out, a_oe;
	logic [4:0]               a_ext = 5'h00;
	logic [4:0]               a_en = 5'h10;
	logic [7:0]               b_in, b_out, b_oe, b_pu;
	logic [7:0]               b_ext = 8'h90;
	logic [7:0]               b_en = 8'hF0;
	int                       bad_count = 0;
	int                       num_checks = 0;
	always #4 mclk = ~mclk;

	dgpio_port dut (.mclk(mclk), .reset(reset), .por(por), .bus(bus), .rdata(rdata),
		.flag_clear(flag_clear), .pin_change_flag(flag), .wake(wake), .bank_a_in(a_in),
		.bank_a_out(a_out), .bank_a_oe(a_oe), .timer_ext_clock_in(tclk),
		.analog_select(asel), .bank_b_in(b_in), .bank_b_out(b_out), .bank_b_oe(b_oe),
		.bank_b_pullup(b_pu));
	dgpio_pins pins (.mclk(mclk), .a_out(a_out), .a_oe(a_oe), .a_ext(a_ext), .a_en(a_en),
		.a_in(a_in), .b_out(b_out), .b_oe(b_oe), .b_pu(b_pu), .b_ext(b_ext), .b_en(b_en),
		.b_in(b_in));

	// ------------------------------------------------------------
	// Bus and compare helpers
	// ------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk) #1;
		bus = '{1'b0, 1'b1, a, d};
		@(posedge mclk) #1;
		bus = '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk) #1;
		bus = '{1'b1, 1'b0, a, 8'h00};
		@(posedge mclk) #1;
		bus = '0;
		d = rdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic clr;
		@(posedge mclk) #1;
		flag_clear = 1'b1;
		@(posedge mclk) #1;
		flag_clear = 1'b0;
	endtask
	task automatic summarize;
		if (bad_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] d;
		rd(8'h85, d);
		chk("dir_a", 8'h1F, d);
		rd(8'h86, d);
		chk("dir_b", 8'hFF, d);
		rd(8'h81, d);
		chk("options", 8'hFF, d);
		rd(8'h9F, d);
		chk("analog", 8'h00, d);
		rd(8'h05, d);
		chk("bank_a", 8'h00, d);
		rd(8'h07, d);
		chk("unmapped", 8'h00, d);
		chk("pullup", 8'h00, b_pu);
	endtask
	task automatic t_bank_b;
		logic [7:0] d;
		wr(8'h86, 8'hF0);
		wr(8'h06, 8'hA5);
		idle(2);
		chk("b_out", 8'hA5, b_out);
		chk("b_oe", 8'h0F, b_oe);
		rd(8'h06, d);
		chk("b_read", 8'h95, d);
		wr(8'h81, 8'h7F);
		idle(2);
		chk("pu_on", 8'hF0, b_pu);
		wr(8'h81, 8'hFF);
		idle(2);
		chk("pu_off", 8'h00, b_pu);
	endtask
	task automatic t_change;
		logic [7:0] d;
		wr(8'h86, 8'h70);
		rd(8'h06, d);
		clr();
		wr(8'h06, 8'h25);
		idle(6);
		chk("flag_out", 8'h00, {7'h0, flag});
		wr(8'h86, 8'hF0);
		idle(3);
		rd(8'h06, d);
		clr();
		chk("flag_idle", 8'h00, {7'h0, flag});
		b_ext = 8'hB0;
		idle(5);
		chk("flag_set", 8'h01, {7'h0, flag});
		chk("wake", 8'h01, {7'h0, wake});
		clr();
		idle(1);
		chk("flag_held", 8'h01, {7'h0, flag});
		rd(8'h06, d);
		clr();
		idle(1);
		chk("flag_clr", 8'h00, {7'h0, flag});
	endtask
	task automatic t_bank_a;
		logic [7:0] d;
		logic [3:0] es [4] = '{4'hF, 4'hF, 4'h3, 4'h0};
		a_ext = 5'h10;
		wr(8'h9F, 8'h03);
		wr(8'h85, 8'h00);
		wr(8'h05, 8'h1F);
		idle(4);
		chk("a_out", 8'h0F, {3'h0, a_out});
		chk("a_oe", 8'h0F, {3'h0, a_oe});
		chk("timer_clk", 8'h01, {7'h0, tclk});
		a_ext = 5'h1A;
		a_en = 5'h1F;
		wr(8'h85, 8'h0F);
		for (int c = 0; c < 4; c++) begin
			wr(8'h9F, 8'(c));
			idle(2);
			chk("asel", {4'h0, es[c]}, {4'h0, asel});
			rd(8'h05, d);
			chk("a_read", {4'h1, 4'hA & ~es[c]}, d);
		end
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		#1;
		reset = 1'b0;
		por = 1'b0;
		t_reset();
		t_bank_b();
		t_change();
		t_bank_a();
		summarize();
	end
	// All scenarios finish in well under 2500 cycles
	initial begin
		#20000;
		bad_count++;
		summarize();
	end
endmodule
